/* File: hw/gpib_listener_defines.vh */
// Shared constants for the listen-only bus command interpreter.
`ifndef GPIB_LISTENER_DEFINES_VH
`define GPIB_LISTENER_DEFINES_VH

// Clock and indicator timing.
`define CLK_PERIOD_NS 5
`define NS_PER_MS 1000000
`define RX_LED_MS 50

// Register byte addresses and bus answers.
`define REG_CTRL 32'h00000000
`define REG_STATUS 32'h00000004
`define REG_SET0 32'h00000008
`define REG_SET1 32'h0000000C
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define CTRL_LISTEN_EN_BIT 0
`define CTRL_LISTEN_EN_RST 1'h1

// Bus command bytes seen while attention is asserted.
`define GPIB_UNL 7'h3F
`define GPIB_LAG_GROUP 2'h1
`define GPIB_DCL 7'h14
`define GPIB_SDC 7'h04

// Characters.
`define CH_LF 8'h0A
`define CH_SPACE 8'h20
`define CH_PLUS 8'h2B
`define CH_MINUS 8'h2D
`define CH_DOT 8'h2E
`define CH_0 8'h30
`define CH_9 8'h39
`define CASE_MASK 8'hDF
`define CH_V 8'h56
`define CH_R 8'h52
`define CH_W 8'h57
`define CH_D 8'h44
`define CH_A 8'h41
`define CH_P 8'h50

// Selector codes.
`define SEL_NONE 3'h0
`define SEL_AMP 3'h1
`define SEL_RATE 3'h2
`define SEL_WIDTH 3'h3
`define SEL_DELAY 3'h4
`define SEL_ADV 3'h5
`define SEL_POL 3'h6

// Ranges in tenths of the unit, quantiser steps and accumulator limits.
`define AMP_MIN10 32'h00000000
`define AMP_MAX10 32'h000003E8
`define RATE_MIN10 32'h0000000A
`define RATE_MAX10 32'h00989680
`define TIME_MIN10 32'h00000001
`define TIME_MAX10 32'h000003E8
`define QSTEPS 32'h000000FF
`define DIGIT_SCALE 28'h000000A
`define ACC_LIMIT 24'h186A00

// Reset values of the settings and of the synchroniser.
`define SET_RST 8'h00
`define POL_POS_RST 1'h1
`define SYNC_INIT 20'hFFFFF

`endif

/* File: hw/line_sync.v */
// Three-stage input synchroniser that only follows a settled level.
`timescale 1ns/100ps
module line_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q_r
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // A bit moves only once stages two and three agree, so a single odd sample is dropped.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q_r <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
    end
  end
endmodule

/* File: hw/gpib_pulse_param_listener.v */
// Listen-only bus command interpreter that sets the pulse generator parameters.
// What this block does
// - Listener only; never talks or requests service.
// - Selectors V, R, W, D, A, P.
// - First non-space character picks parameter; rest ignored.
// - Selector letters match in either case.
// - Value quantised to eight bits over range.
// - Leading and trailing zeros change nothing.
// - Number stops at exponent marker.
// - Out-of-range value discarded, setting kept.
// - Text after the number is ignored.
// - Invalid command leaves every setting unchanged.
// - P with plus or minus sets polarity.
// - Delay and advance set trigger ordering.
// - Factory address eight, from the switches.
// - Address is sum of OFF switch weights.
// - Receive LED pulses per addressed command in remote.
// - Error LED held until valid command.
// - Parameter commands act only in remote; addressing and clears act in either mode.
`timescale 1ns/100ps
`include "gpib_listener_defines.vh"
module gpib_pulse_param_listener #(
  parameter [23:0] RX_LED_CYCLES = (`RX_LED_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  input wire [31:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  input wire [7:0] dio_n,
  input wire dav_n,
  input wire eoi_n,
  input wire atn_n,
  input wire ifc_n,
  input wire nrfd_n_in,
  output reg nrfd_n_out_r,
  output reg nrfd_n_oe_r,
  input wire ndac_n_in,
  output reg ndac_n_out_r,
  output reg ndac_n_oe_r,
  input wire remote_sel,
  input wire [4:0] addr_sw_off,
  output reg [7:0] amp_set_r,
  output reg [7:0] rate_set_r,
  output reg [7:0] width_set_r,
  output reg [7:0] delay_set_r,
  output reg [7:0] adv_set_r,
  output reg pol_pos_r,
  output reg trig_adv_r,
  output reg led_rx_r,
  output reg led_err_r
);
  localparam AH_IDLE = 2'h0;
  localparam AH_HOLD = 2'h1;
  localparam AH_RDY = 2'h2;
  localparam AH_ACPT = 2'h3;
  localparam P_SEL = 3'h0;
  localparam P_SEEK = 3'h1;
  localparam P_INT = 3'h2;
  localparam P_FRAC = 3'h3;
  localparam P_TAIL = 3'h4;

  wire [19:0] syn;
  wire [7:0] dio;
  wire dav;
  wire eoi;
  wire atn;
  wire ifc;
  wire remote;
  wire [4:0] dev_addr;
  wire active;
  wire take;
  wire [6:0] cmd;
  reg [1:0] ah_r;
  reg [1:0] ah_nxt;
  reg listen_r;
  reg clr_r;
  reg rx_stb_r;
  reg [7:0] rx_byte_r;
  reg rx_eoi_r;
  reg [2:0] pst_r;
  reg [2:0] sel_r;
  reg [23:0] val_r;
  reg dig_r;
  reg fdig_r;
  reg neg_r;
  reg ovf_r;
  reg any_r;
  reg eval_r;
  reg [1:0] psign_r;
  reg [23:0] rx_cnt_r;
  reg listen_en_r;
  reg awready_r;
  reg wready_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg arready_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [31:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  // All bus pins and switches come from outside the clock domain.
  line_sync #(.W(20), .INIT(`SYNC_INIT)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({dio_n, dav_n, eoi_n, atn_n, ifc_n, nrfd_n_in, ndac_n_in, remote_sel, addr_sw_off}),
    .q_r(syn)
  );

  // Bus lines are low-true on the wire.
  assign dio = ~syn[19:12];
  assign dav = ~syn[11];
  assign eoi = ~syn[10];
  assign atn = ~syn[9];
  assign ifc = ~syn[8];
  assign remote = syn[5];
  assign dev_addr = syn[4:0];
  assign cmd = dio[6:0];

  assign active = atn | (listen_r & listen_en_r);
  assign take = (ah_r == AH_RDY) & dav & active & ~ifc;

  // Acceptor handshake: NDAC is pulled before NRFD is released; both are released only in AH_IDLE.
  always @* begin
    ah_nxt = ah_r;
    case (ah_r)
      AH_IDLE: begin
        if (active) ah_nxt = AH_HOLD;
      end
      AH_HOLD: begin
        if (!active) ah_nxt = AH_IDLE;
        else if (!dav) ah_nxt = AH_RDY;
      end
      AH_RDY: begin
        if (!active) ah_nxt = AH_IDLE;
        else if (dav) ah_nxt = AH_ACPT;
      end
      AH_ACPT: begin
        if (!dav) ah_nxt = AH_HOLD;
      end
      default: ah_nxt = AH_IDLE;
    endcase
    if (ifc) ah_nxt = AH_IDLE;
  end

  // Handshake lines, addressing and byte capture.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ah_r <= AH_IDLE;
      nrfd_n_out_r <= 1'b0;
      ndac_n_out_r <= 1'b0;
      nrfd_n_oe_r <= 1'b0;
      ndac_n_oe_r <= 1'b0;
      listen_r <= 1'b0;
      clr_r <= 1'b0;
      rx_stb_r <= 1'b0;
      rx_byte_r <= 8'h00;
      rx_eoi_r <= 1'b0;
    end else begin
      ah_r <= ah_nxt;
      nrfd_n_oe_r <= (ah_nxt == AH_HOLD) | (ah_nxt == AH_ACPT);
      ndac_n_oe_r <= (ah_nxt == AH_HOLD) | (ah_nxt == AH_RDY);
      clr_r <= 1'b0;
      rx_stb_r <= 1'b0;
      if (ifc) begin
        listen_r <= 1'b0;
      end else if (take && atn) begin
        if (cmd == `GPIB_UNL) begin
          listen_r <= 1'b0;
        end else if (cmd[6:5] == `GPIB_LAG_GROUP && cmd[4:0] == dev_addr) begin
          listen_r <= 1'b1;
        end
        clr_r <= (cmd == `GPIB_DCL) | ((cmd == `GPIB_SDC) & listen_r);
      end else if (take) begin
        rx_stb_r <= 1'b1;
        rx_byte_r <= dio;
        rx_eoi_r <= eoi;
      end
    end
  end

  wire [7:0] uc;
  wire is_dig;
  wire [27:0] acc_mul;
  wire [23:0] acc_frac;
  wire [31:0] v32;
  reg [31:0] mn;
  reg [31:0] mx;
  reg [31:0] q32;
  wire num_ok;
  wire cmd_ok;

  assign uc = rx_byte_r & `CASE_MASK;
  assign is_dig = (rx_byte_r >= `CH_0) && (rx_byte_r <= `CH_9);
  assign acc_mul = {4'h0, val_r} * `DIGIT_SCALE + {24'h000000, rx_byte_r[3:0]} * `DIGIT_SCALE;
  assign acc_frac = val_r + {20'h00000, rx_byte_r[3:0]};
  assign v32 = {8'h00, val_r};

  always @* begin
    case (sel_r)
      `SEL_AMP: begin
        mn = `AMP_MIN10;
        mx = `AMP_MAX10;
        q32 = ((v32 - `AMP_MIN10) * `QSTEPS) / (`AMP_MAX10 - `AMP_MIN10);
      end
      `SEL_RATE: begin
        mn = `RATE_MIN10;
        mx = `RATE_MAX10;
        q32 = ((v32 - `RATE_MIN10) * `QSTEPS) / (`RATE_MAX10 - `RATE_MIN10);
      end
      `SEL_WIDTH, `SEL_DELAY, `SEL_ADV: begin
        mn = `TIME_MIN10;
        mx = `TIME_MAX10;
        q32 = ((v32 - `TIME_MIN10) * `QSTEPS) / (`TIME_MAX10 - `TIME_MIN10);
      end
      default: begin
        mn = `AMP_MIN10;
        mx = `AMP_MIN10;
        q32 = `AMP_MIN10;
      end
    endcase
  end

  assign num_ok = dig_r & ~neg_r & ~ovf_r & (v32 >= mn) & (v32 <= mx);
  assign cmd_ok = any_r & ((sel_r == `SEL_POL) ? (psign_r != 2'h0) :
                           ((sel_r != `SEL_NONE) & num_ok));

  // Parser and settings; the value is held in tenths, so later fraction digits
  // sit below one quantiser step and are dropped.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pst_r <= P_SEL;
      sel_r <= `SEL_NONE;
      val_r <= 24'h000000;
      dig_r <= 1'b0;
      fdig_r <= 1'b0;
      neg_r <= 1'b0;
      ovf_r <= 1'b0;
      any_r <= 1'b0;
      eval_r <= 1'b0;
      psign_r <= 2'h0;
      rx_cnt_r <= 24'h000000;
      led_rx_r <= 1'b0;
      led_err_r <= 1'b0;
      amp_set_r <= `SET_RST;
      rate_set_r <= `SET_RST;
      width_set_r <= `SET_RST;
      delay_set_r <= `SET_RST;
      adv_set_r <= `SET_RST;
      pol_pos_r <= `POL_POS_RST;
      trig_adv_r <= 1'b0;
    end else begin
      if (rx_cnt_r != 24'h000000) begin
        rx_cnt_r <= rx_cnt_r - 24'h000001;
      end else begin
        led_rx_r <= 1'b0;
      end
      if (eval_r && any_r) begin
        led_rx_r <= 1'b1;
        rx_cnt_r <= RX_LED_CYCLES;
        led_err_r <= ~cmd_ok;
        if (cmd_ok) begin
          case (sel_r)
            `SEL_AMP: amp_set_r <= q32[7:0];
            `SEL_RATE: rate_set_r <= q32[7:0];
            `SEL_WIDTH: width_set_r <= q32[7:0];
            `SEL_DELAY: begin
              delay_set_r <= q32[7:0];
              trig_adv_r <= 1'b0;
            end
            `SEL_ADV: begin
              adv_set_r <= q32[7:0];
              trig_adv_r <= 1'b1;
            end
            `SEL_POL: pol_pos_r <= (psign_r == 2'h1);
            default: pol_pos_r <= pol_pos_r;
          endcase
        end
      end
      if (clr_r || eval_r) begin
        pst_r <= P_SEL;
        sel_r <= `SEL_NONE;
        val_r <= 24'h000000;
        dig_r <= 1'b0;
        fdig_r <= 1'b0;
        neg_r <= 1'b0;
        ovf_r <= 1'b0;
        any_r <= 1'b0;
        eval_r <= 1'b0;
        psign_r <= 2'h0;
      end else if (rx_stb_r && remote) begin
        if (rx_byte_r == `CH_LF) begin
          eval_r <= 1'b1;
        end else begin
          eval_r <= rx_eoi_r;
          case (pst_r)
            P_SEL: begin
              if (rx_byte_r != `CH_SPACE) begin
                any_r <= 1'b1;
                pst_r <= P_SEEK;
                case (uc)
                  `CH_V: sel_r <= `SEL_AMP;
                  `CH_R: sel_r <= `SEL_RATE;
                  `CH_W: sel_r <= `SEL_WIDTH;
                  `CH_D: sel_r <= `SEL_DELAY;
                  `CH_A: sel_r <= `SEL_ADV;
                  `CH_P: sel_r <= `SEL_POL;
                  default: sel_r <= `SEL_NONE;
                endcase
              end
            end
            P_SEEK: begin
              if (is_dig) begin
                val_r <= acc_mul[23:0];
                dig_r <= 1'b1;
                pst_r <= P_INT;
              end else if (rx_byte_r == `CH_DOT) begin
                pst_r <= P_FRAC;
              end else if (rx_byte_r == `CH_PLUS) begin
                psign_r <= 2'h1;
              end else if (rx_byte_r == `CH_MINUS) begin
                psign_r <= 2'h2;
                neg_r <= 1'b1;
              end
            end
            P_INT: begin
              if (is_dig) begin
                if (val_r > `ACC_LIMIT) ovf_r <= 1'b1;
                else val_r <= acc_mul[23:0];
              end else if (rx_byte_r == `CH_DOT) begin
                pst_r <= P_FRAC;
              end else begin
                pst_r <= P_TAIL;
              end
            end
            P_FRAC: begin
              if (is_dig) begin
                dig_r <= 1'b1;
                fdig_r <= 1'b1;
                if (!fdig_r) val_r <= acc_frac;
              end else begin
                pst_r <= P_TAIL;
              end
            end
            P_TAIL: pst_r <= P_TAIL;
            default: pst_r <= P_SEL;
          endcase
        end
      end
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // Register slave: address and data are taken in either order; the write lands
  // one cycle after both are held. Only one write and one read are in flight.
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RESP_OKAY;
      awaddr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      listen_en_r <= `CTRL_LISTEN_EN_RST;
    end else begin
      if (awvalid && awready_r) begin
        awaddr_r <= {awaddr[31:2], 2'h0};
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
        wready_r <= 1'b0;
      end
      if (!awready_r && !wready_r && !bvalid_r) begin
        bvalid_r <= 1'b1;
        bresp_r <= `RESP_OKAY;
        if (awaddr_r == `REG_CTRL) begin
          if (wstrb_r[0]) listen_en_r <= wdata_r[`CTRL_LISTEN_EN_BIT];
        end else if (awaddr_r != `REG_STATUS && awaddr_r != `REG_SET0 &&
                     awaddr_r != `REG_SET1) begin
          bresp_r <= `RESP_DECERR;
        end
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
      if (arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rresp_r <= `RESP_OKAY;
        case ({araddr[31:2], 2'h0})
          `REG_CTRL: rdata_r <= {31'h00000000, listen_en_r};
          `REG_STATUS: rdata_r <= {19'h00000, dev_addr, 2'h0, ~syn[6], ~syn[7], remote,
                                   listen_r, trig_adv_r, led_err_r};
          `REG_SET0: rdata_r <= {delay_set_r, width_set_r, rate_set_r, amp_set_r};
          `REG_SET1: rdata_r <= {23'h000000, pol_pos_r, adv_set_r};
          default: begin
            rdata_r <= 32'h00000000;
            rresp_r <= `RESP_DECERR;
          end
        endcase
      end
      if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end
endmodule

/* File: bench/gpib_listener_properties.sv */
// Checker of the bus handshake, register answers and settings outputs.
`timescale 1ns/100ps
`include "gpib_listener_defines.vh"
module gpib_listener_properties #(
  parameter [23:0] RX_LED_CYCLES = 24'h000008
) (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire [31:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire dav_n,
  input wire remote_sel,
  input wire nrfd_n_out_r,
  input wire nrfd_n_oe_r,
  input wire ndac_n_out_r,
  input wire ndac_n_oe_r,
  input wire [7:0] amp_set_r,
  input wire led_rx_r,
  input wire led_err_r
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg [23:0] run_r;
  // Length of the current receive flash, so its width can be checked exactly.
  // The lamp stays lit one cycle past the count, since the counter reaches zero first.
  always @(posedge aclk)
    if (!aresetn)
      run_r <= 24'h0;
    else
      run_r <= led_rx_r ? run_r + 24'h1 : 24'h0;
  // A byte is taken when NRFD gets pulled while NDAC is let go; pulling both at once
  // only means the acceptor woke up, with no byte on the lines yet.
  sequence byte_taken;
    $rose(nrfd_n_oe_r) && !ndac_n_oe_r;
  endsequence
  chk_drive_low: assert property (nrfd_n_out_r == 1'b0 && ndac_n_out_r == 1'b0)
    else $error("handshake line driven high");
  chk_take_dav: assert property (byte_taken |-> !$past(dav_n, 2))
    else $error("byte taken without data valid");
  chk_hold_nrfd: assert property (byte_taken |-> nrfd_n_oe_r [*3])
    else $error("not ready released too soon");
  chk_ready_again: assert property ($rose(ndac_n_oe_r) |-> dav_n && $past(dav_n))
    else $error("accept withdrawn before data valid released");
  chk_local_hold: assert property ($changed(amp_set_r) |-> $past(remote_sel, 4))
    else $error("setting changed in local mode");
  chk_rx_flash: assert property ($changed(amp_set_r) |-> ##[0:1] led_rx_r)
    else $error("no receive flash on new setting");
  chk_err_clear: assert property ($changed(amp_set_r) |-> ##[0:1] !led_err_r)
    else $error("error lamp kept on valid command");
  chk_rx_len: assert property ($fell(led_rx_r) |-> run_r == RX_LED_CYCLES + 24'h000001)
    else $error("receive flash of wrong length");
  chk_write_resp: assert property (awvalid && awready && wvalid && wready |-> ##1 !bvalid ##1 bvalid)
    else $error("write response late");
  chk_read_resp: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_read_decerr: assert property (arvalid && arready && araddr[31:4] != 28'h0
    |=> rresp == `RESP_DECERR && rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind gpib_pulse_param_listener gpib_listener_properties #(.RX_LED_CYCLES(RX_LED_CYCLES)) props_i (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .dav_n, .remote_sel, .nrfd_n_out_r, .nrfd_n_oe_r, .ndac_n_out_r,
  .ndac_n_oe_r, .amp_set_r, .led_rx_r, .led_err_r);

/* File: bench/gpib_talker_model.sv */
// Bus controller and talker model sending bytes with the three-wire handshake.
`timescale 1ns/100ps
module gpib_talker_model (
  input wire aclk,
  input wire nrfd_n,
  input wire ndac_n,
  output reg [7:0] dio_n,
  output reg dav_n,
  output reg eoi_n,
  output reg atn_n,
  output reg ifc_n
);
  integer n;
  // Bus idle with all control lines released.
  initial begin
    dio_n = 8'hFF;
    dav_n = 1'b1;
    eoi_n = 1'b1;
    atn_n = 1'b1;
    ifc_n = 1'b1;
  end
  // Waits for ready, offers the byte, holds it until accepted.
  // A missing listener is tolerated so that ignored bytes can still be sent.
  task send_byte(input [7:0] b, input atn, input eoi);
    begin
      @(posedge aclk);
      atn_n <= ~atn;
      for (n = 0; n < 40 && !(nrfd_n && !ndac_n); n = n + 1)
        @(posedge aclk);
      dio_n <= ~b;
      eoi_n <= ~eoi;
      dav_n <= 1'b0;
      @(posedge aclk);
      for (n = 0; n < 40 && !ndac_n; n = n + 1)
        @(posedge aclk);
      dav_n <= 1'b1;
      eoi_n <= 1'b1;
      dio_n <= 8'hFF; // Released data lines float up to the idle high level.
    end
  endtask
endmodule

/* File: bench/gpib_pulse_param_listener_tb.sv */
// Self-checking bench driving registers and bus commands into the listener.
`timescale 1ns/100ps
`include "gpib_listener_defines.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module gpib_pulse_param_listener_tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg remote_sel = 1'b1;
  reg [3:0] wstrb = 4'hF;
  reg [4:0] addr_sw_off = 5'h08;
  wire awready, wready, bvalid, arready, rvalid, dav_n, eoi_n, atn_n, ifc_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] dio_n, amp, rate, width, delay, adv;
  wire nrfd_out, nrfd_oe, ndac_out, ndac_oe, pol_pos, trig_adv, led_rx, led_err;
  integer miscompares = 0, n_checks = 0, i;
  reg [47:0] exp_all;
  reg exp_err, exp_adv, done;
  reg [31:0] rd;
  reg [1:0] resp;
  // Pulled-up lines are low only while the device pulls them.
  wire nrfd_n = ~nrfd_oe;
  wire ndac_n = ~ndac_oe;
  wire [47:0] set_all = {7'h00, pol_pos, adv, delay, width, rate, amp};
  always #2.5 aclk = ~aclk;
  gpib_pulse_param_listener #(.RX_LED_CYCLES(24'h000008)) gpib_pulse_param_listener_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .dio_n, .dav_n, .eoi_n, .atn_n, .ifc_n, .nrfd_n_in(nrfd_n), .nrfd_n_out_r(nrfd_out),
    .nrfd_n_oe_r(nrfd_oe), .ndac_n_in(ndac_n), .ndac_n_out_r(ndac_out), .ndac_n_oe_r(ndac_oe),
    .remote_sel, .addr_sw_off, .amp_set_r(amp), .rate_set_r(rate), .width_set_r(width),
    .delay_set_r(delay), .adv_set_r(adv), .pol_pos_r(pol_pos), .trig_adv_r(trig_adv),
    .led_rx_r(led_rx), .led_err_r(led_err));
  gpib_talker_model gpib_talker_model_i (
    .aclk, .nrfd_n, .ndac_n, .dio_n, .dav_n, .eoi_n, .atn_n, .ifc_n);
  // Write with address and data offered together; bready waits for the answer.
  task axi_wr(input [31:0] a, input [31:0] d, output [1:0] r);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) r = bresp;
        done = bvalid;
      end
      bready <= 1'b0;
    end
  endtask
  // Read, taking data and response at the edge where rvalid is seen.
  task axi_rd(input [31:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) d = rdata;
        if (rvalid) r = rresp;
        done = rvalid;
      end
      rready <= 1'b0;
    end
  endtask
  // Sends a command; t picks the end (0 none, 1 line feed, 2 end-or-identify).
  // k is the setting it should change (6 for none), rx the expected flash (2 unchecked).
  task cmd(input string s, input integer k, input [7:0] v, input integer e, t, rx);
    begin
      for (i = 0; i < s.len(); i = i + 1)
        gpib_talker_model_i.send_byte(s[i], 1'b0, t == 2 && i == s.len() - 1);
      if (t == 1) gpib_talker_model_i.send_byte(`CH_LF, 1'b0, 1'b0);
      repeat (3) @(posedge aclk);
      if (rx != 2) `CHK(led_rx, rx[0])
      repeat (12) @(posedge aclk);
      if (k < 6) exp_all[8*k +: 8] = v;
      if (k == 3 || k == 4) exp_adv = (k == 4);
      exp_err = e[0];
      `CHK({set_all, trig_adv, led_err}, {exp_all, exp_adv, exp_err})
    end
  endtask
  task give_verdict;
    begin
      $display("Checks %0d, miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // A hang ends the run as a failure.
  initial begin
    #200000;
    miscompares++;
    give_verdict;
  end
  // Main sequence.
  initial begin
    exp_all = {8'h01, 40'h0};
    exp_err = 1'b0;
    exp_adv = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    axi_rd(`REG_CTRL, rd, resp);
    `CHK({rd, resp}, {32'h1, `RESP_OKAY})
    axi_rd(`REG_STATUS, rd, resp);
    `CHK(rd, 32'h00000808)
    axi_rd(32'h10, rd, resp);
    `CHK({rd, resp}, {32'h0, `RESP_DECERR})
    axi_wr(32'h20, 32'h0, resp);
    `CHK(resp, `RESP_DECERR)
    // A write with no byte lane enabled must leave the listen enable set.
    wstrb <= 4'h0;
    axi_wr(`REG_CTRL, 32'h0, resp);
    wstrb <= 4'hF;
    axi_rd(`REG_CTRL, rd, resp);
    `CHK(rd, 32'h00000001)
    $display("Test registers done");
    gpib_talker_model_i.send_byte(8'h28, 1'b1, 1'b0);
    cmd("v=30", 0, 8'h4C, 0, 1, 1);
    cmd("Voltage of output = 70.2 V", 0, 8'hB3, 0, 1, 1);
    cmd("v 12.82", 0, 8'h20, 0, 1, 1);
    cmd("  V 0030.00", 0, 8'h4C, 0, 1, 1);
    cmd("v 12.83", 0, 8'h20, 0, 1, 1);
    // duty check optional; these rates go out unscreened, as the device allows.
    cmd("r 500000", 1, 8'h7F, 0, 1, 1);
    cmd("R 1000000", 1, 8'hFF, 0, 1, 1);
    cmd("r 1000001", 6, 8'h00, 1, 1, 1);
    cmd("w 3e+3", 2, 8'h07, 0, 1, 1);
    cmd("x 5", 6, 8'h00, 1, 1, 1);
    cmd("w 50 us", 2, 8'h7F, 0, 2, 1);
    cmd("d 100", 3, 8'hFF, 0, 1, 1);
    cmd("a=10", 4, 8'h19, 0, 1, 1);
    cmd("A 0.05", 6, 8'h00, 1, 1, 1);
    cmd("d 0.1", 3, 8'h00, 0, 1, 1);
    cmd("P=-", 5, 8'h00, 0, 1, 1);
    cmd("p+", 5, 8'h01, 0, 1, 1);
    cmd("P 5", 6, 8'h00, 1, 1, 1);
    cmd("v 50", 6, 8'h00, 1, 0, 2);
    cmd("", 0, 8'h7F, 0, 1, 1);
    $display("Test commands done");
    remote_sel <= 1'b0;
    repeat (4) @(posedge aclk);
    cmd("v 10", 6, 8'h00, 0, 1, 0);
    remote_sel <= 1'b1;
    axi_wr(`REG_CTRL, 32'h0, resp);
    cmd("v 20", 6, 8'h00, 0, 1, 0);
    axi_wr(`REG_CTRL, 32'h1, resp);
    gpib_talker_model_i.send_byte(8'h3F, 1'b1, 1'b0);
    cmd("v 10", 6, 8'h00, 0, 1, 0);
    addr_sw_off <= 5'h19;
    gpib_talker_model_i.send_byte(8'h28, 1'b1, 1'b0);
    cmd("v 10", 6, 8'h00, 0, 1, 0);
    gpib_talker_model_i.send_byte(8'h39, 1'b1, 1'b0);
    cmd("v 10", 0, 8'h19, 0, 1, 1);
    // A device clear drops a half-received command, so the later line feed applies nothing.
    cmd("v 9", 6, 8'h00, 0, 0, 2);
    gpib_talker_model_i.send_byte({1'b0, `GPIB_DCL}, 1'b1, 1'b0);
    cmd("", 6, 8'h00, 0, 1, 0);
    $display("Test addressing done");
    axi_rd(`REG_SET0, rd, resp);
    `CHK(rd, exp_all[31:0])
    axi_rd(`REG_SET1, rd, resp);
    `CHK(rd, {23'h0, exp_all[40], exp_all[39:32]})
    axi_rd(`REG_STATUS, rd, resp);
    `CHK({rd[12:8], rd[3:2]}, {5'h19, 2'h3})
    $display("Test readback done");
    give_verdict;
  end
endmodule
